//--- shared/crdc_pkg.sv
// Behaviour
// - two-bit field picks carrier source, resets strength
// - override rate code, reserved codes, resets 001
// - override code used only while enabled
// - audio rate detectable only when allowed
// - 5.94 rate detectable only when allowed or forced by override
// - 2.97 rate detectable only when allowed or forced by override
// - 1.485 rate detectable only when allowed or forced by override
// - 0.27 rate detectable only when allowed or forced by override
// - soft clear holds rate search in reset
// - status reports detected rate code
package crdc_pkg;

  // register bus
  localparam int          ADDR_W    = 8;            // address width
  localparam int          DATA_W    = 16;           // data width
  localparam logic [7:0]  CTRL_OFS  = 8'h4C;        // control register
  localparam logic [7:0]  STAT_OFS  = 8'h4F;        // status register

  // control register fields
  localparam int          METHOD_LSB = 10;          // carrier source, 2 bits
  localparam int          OVR_LSB    = 7;           // override rate, 3 bits
  localparam int          OVREN_BIT  = 6;           // override enable
  localparam int          AUDIO_BIT  = 5;           // allow audio rate
  localparam int          EN6G_BIT   = 4;           // allow 6g rate
  localparam int          EN3G_BIT   = 3;           // allow 3g rate
  localparam int          ENHD_BIT   = 2;           // allow hd rate
  localparam int          ENSD_BIT   = 1;           // allow sd rate
  localparam int          CLR_BIT    = 0;           // soft clear of search
  localparam int          CTRL_MSB   = 11;          // highest stored bit
  localparam logic [15:0] CTRL_RST   = 16'h049E;    // value after reset

  // status register fields
  localparam int          DET_LSB    = 11;          // detected rate, 3 bits
  localparam int          LOCK_BIT   = 9;           // loop locked
  localparam int          LOS_BIT    = 8;           // signal lost

  // rate codes, shared by override and detected fields
  localparam logic [2:0]  RATE_AUDIO = 3'h0;        // 0.125 Gb/s
  localparam logic [2:0]  RATE_SD    = 3'h1;        // 0.270 Gb/s
  localparam logic [2:0]  RATE_HD    = 3'h2;        // 1.485 Gb/s
  localparam logic [2:0]  RATE_3G    = 3'h3;        // 2.97 Gb/s
  localparam logic [2:0]  RATE_6G    = 3'h4;        // 5.94 Gb/s
  localparam int          RATE_NUM   = 5;           // usable codes
  localparam logic [2:0]  DET_RST    = 3'h0;        // detected after reset

  // carrier source codes
  localparam logic [1:0]  METHOD_EDGE = 2'h0;       // edge detection
  localparam logic [1:0]  METHOD_STR  = 2'h1;       // strength detection

  // timing: dwell on each trial rate before moving on
  localparam int          CLK_MHZ   = 200;          // logic clock rate
  localparam int          DWELL_NS  = 1000;         // least dwell time, ns
  localparam int          DWELL_CYC = (DWELL_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W     = 8;            // dwell counter width
  // loop lag plus two sync flops make the fit stale right after a retune
  localparam int          SETTLE_CYC = 4;           // fit ignored this long

  // search states
  typedef enum logic [1:0] {HUNT_IDLE, HUNT_TRY, HUNT_LOCK, HUNT_FORCE}
    crdc_state_t;

endpackage

//--- shared/crdc_ctrl_if.sv
// control fields out of the register file, status back into it
interface crdc_ctrl_if;
  import crdc_pkg::*;
  logic [1:0] method;     // carrier source select
  logic [2:0] ovrRate;    // override rate code
  logic       ovrEn;      // override enable
  logic [4:0] allow;      // rate allow mask, indexed by rate code
  logic       softClear;  // hold search in reset
  logic [2:0] detected;   // detected rate code
  logic       locked;     // loop locked
  logic       lost;       // signal lost

  modport regs (output method, ovrRate, ovrEn, allow, softClear,
                input  detected, locked, lost);
  modport core (input  method, ovrRate, ovrEn, allow, softClear,
                output detected, locked, lost);
endinterface

//--- rtl/crdc_sync.sv
// two-stage synchroniser for pin inputs
module crdc_sync
  import crdc_pkg::*;
#(
  parameter int W = 1                   // bits carried
)(
  input  wire logic         clk,        // logic clock
  input  wire logic         rst_n,      // async reset, active low
  input  wire logic [W-1:0] din,        // asynchronous input
  output logic      [W-1:0] dout        // synchronised output
);

  logic [W-1:0] meta_ff;                // first stage, read only below
  logic [W-1:0] sync_ff;                // second stage

  // the first stage feeds nothing but the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

//--- rtl/crdc_regfile.sv
// control and status registers on the plain register port
module crdc_regfile
  import crdc_pkg::*;
(
  input  wire logic              clk,     // logic clock
  input  wire logic              rst_n,   // async reset, active low
  input  wire logic [ADDR_W-1:0] addr,    // register address
  input  wire logic [DATA_W-1:0] wrData,  // write data
  input  wire logic              wrEn,    // write strobe
  input  wire logic              rdEn,    // read strobe
  output logic      [DATA_W-1:0] rdData,  // read data, next cycle
  crdc_ctrl_if.regs              cif      // fields to the core
);

  logic [CTRL_MSB:0] ctrl_ff;             // stored control bits
  logic [CTRL_MSB:0] nxt_ctrl;
  logic [DATA_W-1:0] rdData_ff;           // read data holding
  logic [DATA_W-1:0] nxt_rdData;
  logic [DATA_W-1:0] statWord;            // assembled status

  // upper control bits are not stored; software keeps them zero
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (wrEn && addr == CTRL_OFS)
      nxt_ctrl = wrData[CTRL_MSB:0];
  end

  // status word from core state
  always_comb
  begin
    statWord = '0;
    statWord[DET_LSB +: 3] = cif.detected;
    statWord[LOCK_BIT] = cif.locked;
    statWord[LOS_BIT] = cif.lost;
  end

  // read mux; unmapped reads answer zero
  always_comb
  begin
    nxt_rdData = '0;
    if (rdEn)
    begin
      case (addr)
        CTRL_OFS: nxt_rdData = {{(DATA_W-CTRL_MSB-1){1'b0}}, ctrl_ff};
        STAT_OFS: nxt_rdData = statWord;
        default:  nxt_rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= CTRL_RST[CTRL_MSB:0];
      rdData_ff <= '0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      rdData_ff <= nxt_rdData;
    end
  end

  // field split; mask index is the rate code
  assign cif.method = ctrl_ff[METHOD_LSB +: 2];
  assign cif.ovrRate = ctrl_ff[OVR_LSB +: 3];
  assign cif.ovrEn = ctrl_ff[OVREN_BIT];
  assign cif.allow = {ctrl_ff[EN6G_BIT], ctrl_ff[EN3G_BIT],
                      ctrl_ff[ENHD_BIT], ctrl_ff[ENSD_BIT],
                      ctrl_ff[AUDIO_BIT]};
  assign cif.softClear = ctrl_ff[CLR_BIT];
  assign rdData = rdData_ff;

endmodule

//--- rtl/crdc_top.sv
// rate detection control for the clock recovery loop
//
// The implementer's own choice: the strobed register port.
module crdc_top
  import crdc_pkg::*;
(
  input  wire logic              clk,            // logic clock, 200 MHz
  input  wire logic              rst_n,          // async reset, active low
  input  wire logic [ADDR_W-1:0] addr,           // register address
  input  wire logic [DATA_W-1:0] wrData,         // register write data
  input  wire logic              wrEn,           // write strobe
  input  wire logic              rdEn,           // read strobe
  output logic      [DATA_W-1:0] rdData,         // read data, next cycle
  input  wire logic              edgeCarrier,    // edge detector, async
  input  wire logic              strengthCarrier,// strength detector, async
  input  wire logic              rateMatch,      // loop fits trial, async
  output logic      [2:0]        retimeRate,     // rate applied to loop
  output logic      [2:0]        detectedRate,   // last found rate
  output logic                   cdrLocked,      // loop locked
  output logic                   signalLost,     // no carrier
  output logic                   carrierPresent, // selected carrier
  output logic                   huntActive      // search not held
);

  crdc_ctrl_if cif ();                           // regfile to core

  logic [2:0] pinSync;                           // synchronised pins
  logic       edgeS;                             // edge carrier, synced
  logic       strS;                              // strength carrier, synced
  logic       matchS;                            // rate match, synced

  crdc_regfile u_regs (
    .clk    (clk),
    .rst_n  (rst_n),
    .addr   (addr),
    .wrData (wrData),
    .wrEn   (wrEn),
    .rdEn   (rdEn),
    .rdData (rdData),
    .cif    (cif.regs)
  );

  crdc_sync #(.W(3)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({rateMatch, strengthCarrier, edgeCarrier}),
    .dout  (pinSync)
  );

  assign edgeS  = pinSync[0];
  assign strS   = pinSync[1];
  assign matchS = pinSync[2];

  // carrier source
  logic carrier_ff;                              // selected carrier
  logic nxt_carrier;
  logic lost_ff;                                 // no carrier, registered
  logic nxt_lost;

  // only code 00 picks edges; the reserved codes fall to strength
  always_comb
  begin
    if (cif.method == METHOD_EDGE)
      nxt_carrier = edgeS;
    else
      nxt_carrier = strS;
    nxt_lost = !nxt_carrier;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      carrier_ff <= 1'b0;
      lost_ff <= 1'b1;
    end
    else
    begin
      carrier_ff <= nxt_carrier;
      lost_ff <= nxt_lost;
    end
  end

  // rate search
  crdc_state_t      state_ff;                    // search state
  crdc_state_t      nxt_state;
  logic [2:0]       trial_ff;                    // rate under trial
  logic [2:0]       nxt_trial;
  logic [CNT_W-1:0] dwell_ff;                    // cycles on this trial
  logic [CNT_W-1:0] nxt_dwell;
  logic [2:0]       det_ff;                      // detected rate
  logic [2:0]       nxt_det;
  logic [2:0]       retime_ff;                   // rate to the loop
  logic [2:0]       nxt_retime;
  logic             lock_ff;                     // lock flag
  logic             nxt_lock;
  logic             active_ff;                   // search not held
  logic             nxt_active;
  logic             forceOk;                     // override code usable

  // next allowed code after cur, wrapping; cur if none other
  function automatic logic [2:0] nextAllowed(input logic [2:0] cur,
                                             input logic [4:0] mask);
    logic [2:0] pick;
    logic [2:0] idx;
    logic       found;
    pick = cur;
    found = 1'b0;
    for (int i = 1; i <= RATE_NUM; i++)
    begin
      idx = 3'((int'(cur) + i) % RATE_NUM);
      if (!found && mask[idx])
      begin
        pick = idx;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  // reserved override codes never lock the loop
  assign forceOk = (cif.ovrRate >= RATE_SD) && (cif.ovrRate <= RATE_6G);

  // next search state; soft clear beats everything, then override
  always_comb
  begin
    nxt_state = state_ff;
    nxt_trial = trial_ff;
    nxt_dwell = dwell_ff;
    nxt_det = det_ff;
    if (cif.softClear)
    begin
      nxt_state = HUNT_IDLE;
      nxt_trial = RATE_AUDIO;
      nxt_dwell = '0;
      nxt_det = DET_RST;
    end
    else if (cif.ovrEn)
    begin
      nxt_state = HUNT_FORCE;
      nxt_dwell = '0;
      if (forceOk && carrier_ff && matchS)
        nxt_det = cif.ovrRate;
    end
    else
    begin
      case (state_ff)
        HUNT_IDLE:
        begin
          // start from the lowest allowed code
          if (|cif.allow)
          begin
            nxt_state = HUNT_TRY;
            nxt_trial = nextAllowed(3'(RATE_NUM - 1), cif.allow);
            nxt_dwell = '0;
          end
        end
        HUNT_TRY:
        begin
          if (!(|cif.allow))
            nxt_state = HUNT_IDLE;
          else if (!cif.allow[trial_ff])
          begin
            // rate withdrawn while under trial
            nxt_trial = nextAllowed(trial_ff, cif.allow);
            nxt_dwell = '0;
          end
          // a fit seen before the retuned loop settles is stale
          else if (carrier_ff && matchS
                   && dwell_ff >= CNT_W'(SETTLE_CYC))
          begin
            nxt_state = HUNT_LOCK;
            nxt_det = trial_ff;
          end
          else if (dwell_ff == CNT_W'(DWELL_CYC - 1))
          begin
            nxt_trial = nextAllowed(trial_ff, cif.allow);
            nxt_dwell = '0;
          end
          else
            nxt_dwell = dwell_ff + 1'b1;
        end
        HUNT_LOCK:
        begin
          // disallowed rate, lost carrier or slip restarts the search
          if (!cif.allow[trial_ff] || !carrier_ff || !matchS)
          begin
            nxt_state = HUNT_IDLE;
            nxt_dwell = '0;
          end
        end
        HUNT_FORCE:
        begin
          // override released: search again from scratch
          nxt_state = HUNT_IDLE;
          nxt_dwell = '0;
        end
        default:
          nxt_state = HUNT_IDLE;
      endcase
    end
  end

  // loop rate and lock follow the next state, so outputs match it
  always_comb
  begin
    nxt_retime = nxt_trial;
    nxt_lock = (nxt_state == HUNT_LOCK);
    nxt_active = !cif.softClear;
    if (nxt_state == HUNT_FORCE)
    begin
      nxt_retime = cif.ovrRate;
      nxt_lock = forceOk && carrier_ff && matchS;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= HUNT_IDLE;
      trial_ff <= RATE_AUDIO;
      dwell_ff <= '0;
      det_ff <= DET_RST;
      retime_ff <= RATE_AUDIO;
      lock_ff <= 1'b0;
      active_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      trial_ff <= nxt_trial;
      dwell_ff <= nxt_dwell;
      det_ff <= nxt_det;
      retime_ff <= nxt_retime;
      lock_ff <= nxt_lock;
      active_ff <= nxt_active;
    end
  end

  // status back to the register file
  assign cif.detected = det_ff;
  assign cif.locked = lock_ff;
  assign cif.lost = lost_ff;

  assign retimeRate = retime_ff;
  assign detectedRate = det_ff;
  assign cdrLocked = lock_ff;
  assign signalLost = lost_ff;
  assign carrierPresent = carrier_ff;
  assign huntActive = active_ff;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  carrier_select_a: assert property (
    ##1 carrier_ff == ($past(cif.method) == METHOD_EDGE ?
                       $past(edgeS) : $past(strS)))
    else $error("carrier source does not follow method field");

  forced_rate_a: assert property (
    cif.ovrEn && !cif.softClear |=> retime_ff == $past(cif.ovrRate)
                                    && state_ff == HUNT_FORCE)
    else $error("override rate not applied");

  auto_rate_a: assert property (
    !cif.ovrEn |=> state_ff != HUNT_FORCE
                   && (state_ff != HUNT_LOCK || retime_ff == det_ff))
    else $error("auto selection not in force while override off");

  audio_excl_a: assert property (
    state_ff == HUNT_LOCK && det_ff == RATE_AUDIO && !cif.allow[0]
    && !cif.ovrEn |=> state_ff != HUNT_LOCK)
    else $error("locked to disallowed audio rate");

  uhd_excl_a: assert property (
    state_ff == HUNT_LOCK && det_ff == RATE_6G && !cif.allow[4]
    && !cif.ovrEn |=> state_ff != HUNT_LOCK)
    else $error("locked to disallowed 5.94 rate");

  three_g_excl_a: assert property (
    state_ff == HUNT_LOCK && det_ff == RATE_3G && !cif.allow[3]
    && !cif.ovrEn |=> state_ff != HUNT_LOCK)
    else $error("locked to disallowed 2.97 rate");

  hd_excl_a: assert property (
    state_ff == HUNT_LOCK && det_ff == RATE_HD && !cif.allow[2]
    && !cif.ovrEn |=> state_ff != HUNT_LOCK)
    else $error("locked to disallowed 1.485 rate");

  sd_excl_a: assert property (
    state_ff == HUNT_LOCK && det_ff == RATE_SD && !cif.allow[1]
    && !cif.ovrEn |=> state_ff != HUNT_LOCK)
    else $error("locked to disallowed 0.27 rate");

  soft_clear_a: assert property (
    cif.softClear [*2] |-> state_ff == HUNT_IDLE && !lock_ff
                           && det_ff == DET_RST && !huntActive)
    else $error("soft clear does not hold the search");

  status_read_a: assert property (
    rdEn && addr == STAT_OFS |=> rdData[DET_LSB +: 3] == $past(det_ff)
                                 && rdData[LOCK_BIT] == $past(lock_ff))
    else $error("status read does not show detected rate");

  lock_entry_a: assert property (
    $rose(state_ff == HUNT_LOCK) |-> $past(cif.allow[trial_ff])
                                     && det_ff == $past(trial_ff))
    else $error("lock entered on a disallowed rate");

  dwell_step_a: assert property (
    state_ff == HUNT_TRY && dwell_ff == CNT_W'(DWELL_CYC - 1)
    && !matchS && !cif.softClear && !cif.ovrEn
    && cif.allow[trial_ff] |=> dwell_ff == '0)
    else $error("dwell counter did not restart on rate step");

endmodule

//--- tb/crdc_stream_model.sv
// incoming serial stream: carrier detectors and loop fit at one rate
module crdc_stream_model
  import crdc_pkg::*;
(
  input  wire logic       clk,             // logic clock
  input  wire logic       rst_n,           // async reset, active low
  input  wire logic [2:0] retimeRate,      // rate the loop is tuned to
  input  wire logic [2:0] streamRate,      // true rate of the stream
  input  wire logic       edgeOn,          // edge detector sees carrier
  input  wire logic       strengthOn,      // strength detector sees one
  output logic            edgeCarrier,     // edge detector pin
  output logic            strengthCarrier, // strength detector pin
  output logic            rateMatch        // loop fits the stream
);
  timeunit 1ns;
  timeprecision 100ps;

  logic lockFit_ff; // fit lags the tuning by one cycle, like a real loop

  // the loop only fits while some carrier exists and the rate agrees
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lockFit_ff <= 1'b0;
    else
      lockFit_ff <= (edgeOn | strengthOn) && (retimeRate === streamRate);
  end

  assign edgeCarrier     = edgeOn;
  assign strengthCarrier = strengthOn;
  assign rateMatch       = lockFit_ff;
endmodule

//--- tb/cdr_rate_detect_control_bench.sv
// register and search checks of the rate detection control
module cdr_rate_detect_control_bench
  import crdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              clk;             // logic clock
  logic              rst_n;           // async reset, active low
  logic [ADDR_W-1:0] addr;            // register address
  logic [DATA_W-1:0] wrData;          // write data
  logic              wrEn;            // write strobe
  logic              rdEn;            // read strobe
  logic [DATA_W-1:0] rdData;          // read data
  logic              edgeCarrier;     // edge detector pin
  logic              strengthCarrier; // strength detector pin
  logic              rateMatch;       // loop fit pin
  logic [2:0]        retimeRate;      // applied rate
  logic [2:0]        detectedRate;    // found rate
  logic              cdrLocked;       // locked flag
  logic              signalLost;      // loss flag
  logic              carrierPresent;  // selected carrier
  logic              huntActive;      // search running
  logic [2:0]        streamRate;      // stream rate given to the model
  logic              edgeOn;          // edge carrier on
  logic              strengthOn;      // strength carrier on
  int                mismatches;      // failed comparisons
  int                nCompared;       // all comparisons
  logic [DATA_W-1:0] got;             // last read value
  logic              ok;              // lock seen

  crdc_top crdc_top_i (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .rdData(rdData), .edgeCarrier(edgeCarrier),
    .strengthCarrier(strengthCarrier), .rateMatch(rateMatch),
    .retimeRate(retimeRate), .detectedRate(detectedRate),
    .cdrLocked(cdrLocked), .signalLost(signalLost),
    .carrierPresent(carrierPresent), .huntActive(huntActive));

  crdc_stream_model crdc_stream_model_i (
    .clk(clk), .rst_n(rst_n), .retimeRate(retimeRate),
    .streamRate(streamRate), .edgeOn(edgeOn), .strengthOn(strengthOn),
    .edgeCarrier(edgeCarrier), .strengthCarrier(strengthCarrier),
    .rateMatch(rateMatch));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // control word; software keeps bits 15:12 at zero
  function automatic logic [15:0] ctrl(input logic [1:0] m,
    input logic [2:0] o, input logic oe, input logic [4:0] al,
    input logic c);
    ctrl = {4'h0, m, o, oe, al[RATE_AUDIO], al[RATE_6G], al[RATE_3G],
            al[RATE_HD], al[RATE_SD], c};
  endfunction

  // one-cycle write strobe
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge clk);
    wrEn   <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle only
  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    d = rdData;
  endtask

  task automatic check_reg(input logic [15:0] g, input logic [15:0] e);
    nCompared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic check_rate(input logic [2:0] g, input logic [2:0] e);
    nCompared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t rate got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic check_flag(input logic g, input logic e);
    nCompared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t flag got=%h exp=%h", $time, g, e);
    end
  endtask

  // bounded wait for the lock flag
  task automatic wait_lock(input int lim, output logic seen);
    seen = 1'b0;
    repeat (lim)
    begin
      @(posedge clk);
      #1;
      if (cdrLocked === 1'b1)
      begin
        seen = 1'b1;
        break;
      end
    end
  endtask

  // restart the search under a new control word
  task automatic restart(input logic [15:0] c);
    reg_write(CTRL_OFS, c | 16'h0001);
    reg_write(CTRL_OFS, c);
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog: the tests need about 11000 cycles
  initial
  begin
    #250000;
    mismatches++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 8'h00;
    wrData = 16'h0000;
    wrEn = 1'b0;
    rdEn = 1'b0;
    streamRate = RATE_SD;
    edgeOn = 1'b0;
    strengthOn = 1'b0;
    mismatches = 0;
    nCompared = 0;
    repeat (5) @(posedge clk);
    check_flag(signalLost, 1'b1);
    check_flag(huntActive, 1'b0);
    rst_n <= 1'b1;
    reg_read(CTRL_OFS, got);
    check_reg(got, 16'h049E);
    reg_write(8'h4D, 16'h0ABC);
    reg_read(8'h4D, got);
    check_reg(got, 16'h0000);
    reg_write(CTRL_OFS, 16'h0B5A);
    reg_read(CTRL_OFS, got);
    check_reg(got, 16'h0B5A);
    $display("test registers done");

    // carrier source select
    @(posedge clk);
    edgeOn <= 1'b1;
    reg_write(CTRL_OFS, ctrl(METHOD_EDGE, RATE_SD, 1'b0, 5'h1E, 1'b0));
    repeat (6) @(posedge clk);
    #1;
    check_flag(carrierPresent, 1'b1);
    check_flag(signalLost, 1'b0);
    reg_write(CTRL_OFS, ctrl(METHOD_STR, RATE_SD, 1'b0, 5'h1E, 1'b0));
    repeat (6) @(posedge clk);
    #1;
    check_flag(carrierPresent, 1'b0);
    reg_read(STAT_OFS, got);
    check_reg(got & 16'h0100, 16'h0100);
    @(posedge clk);
    edgeOn <= 1'b0;
    strengthOn <= 1'b1;
    $display("test carrier source done");

    // each rate locks when allowed and is never found when not
    for (int r = 0; r < RATE_NUM; r++)
    begin
      streamRate <= 3'(r);
      restart(ctrl(METHOD_STR, RATE_SD, 1'b0, 5'h1F, 1'b0));
      wait_lock(1300, ok);
      check_flag(ok, 1'b1);
      check_rate(detectedRate, 3'(r));
      reg_read(STAT_OFS, got);
      check_reg(got, {2'b00, 3'(r), 11'h200});
      // drop the locked rate without a clear: the lock must let go
      reg_write(CTRL_OFS, ctrl(METHOD_STR, RATE_SD, 1'b0,
                               5'h1F & ~(5'h01 << r), 1'b0));
      wait_lock(1300, ok);
      check_flag(ok, 1'b0);
    end
    $display("test rate allow done");

    // soft clear holds the search
    streamRate <= RATE_HD;
    restart(ctrl(METHOD_STR, RATE_SD, 1'b0, 5'h1E, 1'b0));
    wait_lock(1300, ok);
    check_flag(ok, 1'b1);
    reg_write(CTRL_OFS, ctrl(METHOD_STR, RATE_SD, 1'b0, 5'h1E, 1'b1));
    repeat (300) @(posedge clk);
    #1;
    check_flag(huntActive, 1'b0);
    check_flag(cdrLocked, 1'b0);
    check_rate(detectedRate, RATE_AUDIO);
    reg_write(CTRL_OFS, ctrl(METHOD_STR, RATE_SD, 1'b0, 5'h1E, 1'b0));
    repeat (2) @(posedge clk);
    #1;
    check_flag(huntActive, 1'b1);
    $display("test soft clear done");

    // override applies its code only while enabled
    streamRate <= RATE_6G;
    restart(ctrl(METHOD_STR, RATE_6G, 1'b0, 5'h02, 1'b0));
    wait_lock(1300, ok);
    check_flag(ok, 1'b0);
    reg_write(CTRL_OFS, ctrl(METHOD_STR, RATE_6G, 1'b1, 5'h02, 1'b0));
    wait_lock(20, ok);
    check_flag(ok, 1'b1);
    check_rate(retimeRate, RATE_6G);
    reg_write(CTRL_OFS, ctrl(METHOD_STR, 3'h5, 1'b1, 5'h02, 1'b0));
    repeat (3) @(posedge clk);
    wait_lock(300, ok);
    check_flag(ok, 1'b0);
    check_rate(retimeRate, 3'h5);
    $display("test override done");
    print_verdict();
  end
endmodule
